// ---- common/hkadc_pkg.sv ----
// Shared constants and types for the housekeeping converter control block
package hkadc_pkg;
    // Special function register addresses
    localparam logic [7:0] ADDR_TEMP_RESULT = 8'hD7;
    localparam logic [7:0] ADDR_CONV_START = 8'hD8;
    localparam logic [7:0] ADDR_BAT_RESULT = 8'hDF;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hEC;
    localparam logic [7:0] ADDR_EXT_RESULT = 8'hEF;
    localparam logic [7:0] ADDR_DELTA_CFG = 8'hF3;
    localparam logic [7:0] ADDR_IRQ_FLAGS = 8'hF8;
    localparam logic [7:0] ADDR_STROBE_PER = 8'hF9;
    localparam logic [7:0] ADDR_BAT_THRESH = 8'hFA;

    // Field positions and masks
    localparam int EXT_DELTA_LSB = 0;
    localparam int TEMP_DELTA_LSB = 3;
    localparam int BAT_PER_LSB = 0;
    localparam int EXT_PER_LSB = 2;
    localparam int TEMP_PER_LSB = 4;
    localparam int FLAG_LOW_BAT = 0;
    localparam int FLAG_EXT_CHANGE = 1;
    localparam logic [7:0] START_MASK = 8'h07;
    localparam logic [7:0] DELTA_MASK = 8'h3F;
    localparam logic [7:0] PERIOD_MASK = 8'h3F;
    localparam logic [7:0] FLAG_MASK = 8'h03;
    localparam logic [2:0] DELTA_OFF = 3'h0;
    localparam logic [2:0] DELTA_ALL = 3'h7;
    localparam logic [1:0] PERIOD_OFF = 2'h0;
    localparam logic [1:0] CNT_ONE = 2'h1;

    typedef enum logic [1:0] {
        MODE_FULL = 2'b00,
        MODE_BATT = 2'b01,
        MODE_SLEEP = 2'b10
    } hkadc_mode_t;

    // Channel code equals its start bit position
    typedef enum logic [1:0] {
        CH_BAT = 2'b00,
        CH_TEMP = 2'b01,
        CH_EXT = 2'b10
    } hkadc_chan_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_WAIT = 1'b1
    } hkadc_fsm_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic [7:0] wdata;
    } hkadc_sfr_t;

    typedef struct packed {
        logic done;
        logic [7:0] code;
    } hkadc_conv_t;

    typedef struct packed {
        hkadc_fsm_t state;
        hkadc_chan_t chan;
        logic single;
        logic [2:0] start;
        logic [2:0] due;
        logic [2:0][1:0] cnt;
        logic [7:0] temp_res;
        logic [7:0] bat_res;
        logic [7:0] ext_res;
        logic [7:0] temp_ref;
        logic [7:0] ext_ref;
        logic [7:0] irq_en;
        logic [7:0] flags;
        logic [7:0] delta;
        logic [7:0] period;
        logic [7:0] thresh;
        logic [7:0] rdata;
        logic temp_irq;
        logic ext_irq;
        logic psm_irq;
        logic req;
        hkadc_chan_t req_chan;
    } hkadc_regs_t;

    localparam hkadc_regs_t REGS_RESET = '0;
endpackage

// ---- core/hkadc_ctrl.sv ----
// Housekeeping converter control: scheduling, delta compare, flags, result SFRs
// Operation
// - Full-power mode takes single and background temperature conversions.
// - Battery run mode takes only single temperature conversions.
// - Sleep mode takes only background temperature conversions.
// - Temperature result loads only when its interrupt is raised.
// - Temperature interrupt on delta exceeded or on single completion.
// - Temperature interrupt sets no software-visible flag.
// - Battery result is an 8-bit code, 14.6 mV per step.
// - Battery start bit converts once and sets the low-battery flag on result.
// - Battery background conversions run at the 2-bit battery interval.
// - Background battery result below threshold sets the low-battery flag.
// - Low-battery flag drives power interrupt only when enabled.
// - Battery: both in full power, single in battery run, none asleep.
// - Battery result loads only when the low-battery flag is set.
// - External voltage result is an 8-bit code, 15.3 mV per step.
// - External start bit converts once and interrupts on result.
// - External background off after reset, runs once interval nonzero.
// - Background external delta exceeded sets the external change flag.
// - External change flag drives power interrupt only when enabled.
// - External: both in full power, single in battery run, background asleep.
// - External result loads only when its interrupt is raised.
// - Start bits clear once the converter takes the request.
// - Delta zero never interrupts, one to six threshold, seven always.
`timescale 1ns/1ps
`default_nettype none
module hkadc_ctrl (
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // Special function register access
    input wire hkadc_pkg::hkadc_sfr_t sfr_i,
    output var logic [7:0] sfr_rdata_o,
    // Power-saving mode and interval base
    input wire hkadc_pkg::hkadc_mode_t mode_i,
    input wire logic interval_tick_i,
    // Converter handshake
    input wire hkadc_pkg::hkadc_conv_t conv_i,
    output var logic conv_req_o,
    output var hkadc_pkg::hkadc_chan_t conv_chan_o,
    // Interrupts
    output var logic temp_irq_o,
    output var logic ext_irq_o,
    output var logic psm_irq_o
);
    import hkadc_pkg::*;

    hkadc_regs_t q;
    hkadc_regs_t next_q;

    function automatic logic delta_hit(input logic [7:0] code, input logic [7:0] ref_v,
                                       input logic [2:0] d);
        logic [7:0] diff;
        diff = (code > ref_v) ? code - ref_v : ref_v - code;
        if (d == DELTA_OFF)
            return 1'b0;
        else if (d == DELTA_ALL)
            return 1'b1;
        else
            return diff > {5'h00, d};
    endfunction

    function automatic logic [1:0] period_of(input logic [7:0] per, input int ch);
        if (ch == int'(CH_BAT))
            return per[BAT_PER_LSB +: 2];
        else if (ch == int'(CH_EXT))
            return per[EXT_PER_LSB +: 2];
        else
            return per[TEMP_PER_LSB +: 2];
    endfunction

    function automatic logic single_ok(input hkadc_mode_t m);
        // Core is halted in sleep, so no software start is honoured there
        return (m == MODE_FULL) || (m == MODE_BATT);
    endfunction

    function automatic logic bg_ok(input hkadc_mode_t m, input int ch);
        if (m == MODE_FULL)
            return 1'b1;
        else if (m == MODE_SLEEP)
            return ch != int'(CH_BAT);
        else
            return 1'b0;
    endfunction

    function automatic logic [7:0] read_mux(input logic [7:0] a, input hkadc_regs_t r);
        if (a == ADDR_TEMP_RESULT)
            return r.temp_res;
        else if (a == ADDR_CONV_START)
            return {5'h00, r.start};
        else if (a == ADDR_BAT_RESULT)
            return r.bat_res;
        else if (a == ADDR_IRQ_ENABLE)
            return r.irq_en;
        else if (a == ADDR_EXT_RESULT)
            return r.ext_res;
        else if (a == ADDR_DELTA_CFG)
            return r.delta;
        else if (a == ADDR_IRQ_FLAGS)
            return r.flags;
        else if (a == ADDR_STROBE_PER)
            return r.period;
        else if (a == ADDR_BAT_THRESH)
            return r.thresh;
        else
            return 8'h00;
    endfunction

    always_comb
    begin
        logic found;
        logic pick_single;
        logic [1:0] pick;
        logic [1:0] per;
        logic hit;
        logic [2:0] new_start;
        logic [2:0] new_due;
        found = 1'b0;
        pick_single = 1'b0;
        pick = 2'b00;
        per = PERIOD_OFF;
        hit = 1'b0;
        new_start = 3'h0;
        new_due = 3'h0;
        next_q = q;
        next_q.temp_irq = 1'b0;
        next_q.ext_irq = 1'b0;
        next_q.req = 1'b0;

        if (sfr_i.wr)
        begin
            if (sfr_i.addr == ADDR_CONV_START)
            begin
                // Kept apart so a start written while its channel is picked survives
                new_start = sfr_i.wdata[2:0];
                next_q.start = q.start | new_start;
            end
            else if (sfr_i.addr == ADDR_IRQ_ENABLE)
                next_q.irq_en = sfr_i.wdata & FLAG_MASK;
            else if (sfr_i.addr == ADDR_DELTA_CFG)
                next_q.delta = sfr_i.wdata & DELTA_MASK;
            else if (sfr_i.addr == ADDR_IRQ_FLAGS)
                next_q.flags = q.flags & sfr_i.wdata;
            else if (sfr_i.addr == ADDR_STROBE_PER)
                next_q.period = sfr_i.wdata & PERIOD_MASK;
            else if (sfr_i.addr == ADDR_BAT_THRESH)
                next_q.thresh = sfr_i.wdata;
        end

        // Interval counters; field value n means one strobe every n ticks
        for (int i = 0; i < 3; i++)
        begin
            per = period_of(q.period, i);
            if (per == PERIOD_OFF)
            begin
                next_q.cnt[i] = PERIOD_OFF;
                next_q.due[i] = 1'b0;
            end
            else if (interval_tick_i)
            begin
                if (q.cnt[i] + CNT_ONE >= per)
                begin
                    next_q.cnt[i] = PERIOD_OFF;
                    if (bg_ok(mode_i, i))
                    begin
                        new_due[i] = 1'b1;
                        next_q.due[i] = 1'b1;
                    end
                end
                else
                    next_q.cnt[i] = q.cnt[i] + CNT_ONE;
            end
        end

        case (q.state)
            ST_IDLE:
            begin
                // Lowest channel code wins; the rest stay latched for later
                for (int i = 2; i >= 0; i--)
                begin
                    if (q.start[i] && single_ok(mode_i))
                    begin
                        found = 1'b1;
                        pick = i[1:0];
                        pick_single = 1'b1;
                    end
                    else if (q.due[i] && bg_ok(mode_i, i))
                    begin
                        found = 1'b1;
                        pick = i[1:0];
                        pick_single = 1'b0;
                    end
                end
                if (found)
                begin
                    next_q.req = 1'b1;
                    next_q.req_chan = hkadc_chan_t'(pick);
                    next_q.chan = hkadc_chan_t'(pick);
                    next_q.single = pick_single;
                    // A request that lands in this same cycle wins over the clear
                    if (pick_single)
                        next_q.start[pick] = new_start[pick];
                    else
                        next_q.due[pick] = new_due[pick];
                    next_q.state = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                if (conv_i.done)
                begin
                    next_q.state = ST_IDLE;
                    if (q.chan == CH_TEMP)
                    begin
                        hit = delta_hit(conv_i.code, q.temp_ref,
                                        q.delta[TEMP_DELTA_LSB +: 3]);
                        if (hit || q.single)
                        begin
                            next_q.temp_irq = 1'b1;
                            next_q.temp_res = conv_i.code;
                            next_q.temp_ref = conv_i.code;
                        end
                    end
                    else if (q.chan == CH_BAT)
                    begin
                        if (q.single || (conv_i.code < q.thresh))
                        begin
                            next_q.flags[FLAG_LOW_BAT] = 1'b1;
                            next_q.bat_res = conv_i.code;
                        end
                    end
                    else
                    begin
                        hit = delta_hit(conv_i.code, q.ext_ref,
                                        q.delta[EXT_DELTA_LSB +: 3]);
                        if (hit || q.single)
                        begin
                            next_q.ext_irq = 1'b1;
                            next_q.ext_res = conv_i.code;
                            next_q.ext_ref = conv_i.code;
                        end
                        if (hit && !q.single)
                            next_q.flags[FLAG_EXT_CHANGE] = 1'b1;
                    end
                end
            end
            default:
                next_q.state = ST_IDLE;
        endcase

        // One cycle behind the flags, which keeps the output a plain flop
        next_q.psm_irq = |(q.flags & q.irq_en);
        next_q.rdata = read_mux(sfr_i.addr, q);
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            q <= REGS_RESET;
        else
            q <= next_q;
    end

    assign sfr_rdata_o = q.rdata;
    assign conv_req_o = q.req;
    assign conv_chan_o = q.req_chan;
    assign temp_irq_o = q.temp_irq;
    assign ext_irq_o = q.ext_irq;
    assign psm_irq_o = q.psm_irq;

    sequence s_temp_single_done;
        q.state == ST_WAIT && q.chan == CH_TEMP && q.single && conv_i.done;
    endsequence

    sequence s_ext_single_done;
        q.state == ST_WAIT && q.chan == CH_EXT && q.single && conv_i.done;
    endsequence

    sequence s_bat_low_done;
        q.state == ST_WAIT && q.chan == CH_BAT && conv_i.done && conv_i.code < q.thresh;
    endsequence

    sequence s_bat_single_done;
        q.state == ST_WAIT && q.chan == CH_BAT && q.single && conv_i.done;
    endsequence

    property p_irq_after(s, logic irq);
        @(posedge clock_i) disable iff (reset_i)
        s |=> irq;
    endproperty

    a_temp_single_irq: assert property (p_irq_after(s_temp_single_done, q.temp_irq))
        else $error("single temperature conversion gave no interrupt");

    a_ext_single_irq: assert property (p_irq_after(s_ext_single_done, q.ext_irq))
        else $error("single external conversion gave no interrupt");

    a_low_bat_flag: assert property (@(posedge clock_i) disable iff (reset_i)
        s_bat_low_done |=> q.flags[FLAG_LOW_BAT] && q.bat_res == $past(conv_i.code))
        else $error("low battery result did not set flag and result");

    a_temp_no_bg_batt: assert property (@(posedge clock_i) disable iff (reset_i)
        q.req && q.req_chan == CH_TEMP && $past(mode_i) == MODE_BATT |-> q.single)
        else $error("background temperature conversion in battery run mode");

    a_no_single_sleep: assert property (@(posedge clock_i) disable iff (reset_i)
        q.req && $past(mode_i) == MODE_SLEEP |-> !q.single)
        else $error("single conversion started in sleep mode");

    a_no_bat_sleep: assert property (@(posedge clock_i) disable iff (reset_i)
        q.req && q.req_chan == CH_BAT |-> $past(mode_i) != MODE_SLEEP)
        else $error("battery conversion started in sleep mode");

    a_temp_res_hold: assert property (@(posedge clock_i) disable iff (reset_i)
        $changed(q.temp_res) |-> q.temp_irq)
        else $error("temperature result changed without interrupt");

    a_ext_res_hold: assert property (@(posedge clock_i) disable iff (reset_i)
        $changed(q.ext_res) |-> q.ext_irq && q.ext_ref == q.ext_res)
        else $error("external result changed without interrupt");

    a_bat_res_flag: assert property (@(posedge clock_i) disable iff (reset_i)
        $changed(q.bat_res) |-> q.flags[FLAG_LOW_BAT])
        else $error("battery result changed without low battery flag");

    a_start_self_clear: assert property (@(posedge clock_i) disable iff (reset_i)
        q.req && q.single && !$past(sfr_i.wr) |-> !q.start[q.req_chan])
        else $error("start bit not cleared on request");

    a_psm_irq_gate: assert property (@(posedge clock_i) disable iff (reset_i)
        q.psm_irq == |($past(q.flags) & $past(q.irq_en)))
        else $error("power interrupt does not follow enabled flags");

    a_ext_bg_off: assert property (@(posedge clock_i) disable iff (reset_i)
        q.period[EXT_PER_LSB +: 2] == PERIOD_OFF |=> !q.due[CH_EXT])
        else $error("external background due while interval is off");

    a_delta_off_quiet: assert property (@(posedge clock_i) disable iff (reset_i)
        q.state == ST_WAIT && q.chan == CH_TEMP && !q.single && conv_i.done
        && q.delta[TEMP_DELTA_LSB +: 3] == DELTA_OFF |=> !q.temp_irq)
        else $error("temperature interrupt with delta setting zero");

    a_one_at_a_time: assert property (@(posedge clock_i) disable iff (reset_i)
        q.req |=> !q.req)
        else $error("two converter requests back to back");

    a_bat_single_flag: assert property (@(posedge clock_i) disable iff (reset_i)
        s_bat_single_done |=> q.flags[FLAG_LOW_BAT] && q.bat_res == $past(conv_i.code))
        else $error("single battery conversion did not set flag and result");

    a_bat_no_bg_batt: assert property (@(posedge clock_i) disable iff (reset_i)
        q.req && q.req_chan == CH_BAT && $past(mode_i) == MODE_BATT |-> q.single)
        else $error("background battery conversion in battery run mode");

    a_ext_no_bg_batt: assert property (@(posedge clock_i) disable iff (reset_i)
        q.req && q.req_chan == CH_EXT && $past(mode_i) == MODE_BATT |-> q.single)
        else $error("background external conversion in battery run mode");

    a_ext_single_noflag: assert property (@(posedge clock_i) disable iff (reset_i)
        s_ext_single_done |=> !$rose(q.flags[FLAG_EXT_CHANGE]))
        else $error("single external conversion set the change flag");

    a_temp_no_flag: assert property (@(posedge clock_i) disable iff (reset_i)
        q.temp_irq |-> !$rose(q.flags[FLAG_LOW_BAT]) && !$rose(q.flags[FLAG_EXT_CHANGE]))
        else $error("temperature interrupt raised a status flag");

    a_temp_ref_renew: assert property (@(posedge clock_i) disable iff (reset_i)
        q.temp_irq |-> q.temp_ref == q.temp_res)
        else $error("temperature reference not renewed on interrupt");

    a_temp_due_mode: assert property (@(posedge clock_i) disable iff (reset_i)
        $rose(q.due[CH_TEMP]) |-> $past(mode_i) != MODE_BATT)
        else $error("temperature background strobe kept in battery run mode");
endmodule // hkadc_ctrl
`default_nettype wire

// ---- verif/hkadc_conv_model.sv ----
// Behavioural converter that answers each request after a chosen latency
`timescale 1ns/1ps
`default_nettype none
module hkadc_conv_model (
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // Request from the control block and bench controls
    input wire logic req_i,
    input wire logic [3:0] latency_i,
    input wire logic [7:0] code_i,
    // Answer
    output var hkadc_pkg::hkadc_conv_t conv_o
);
    import hkadc_pkg::*;
    logic busy;
    logic [3:0] wait_cnt;
    logic [7:0] last;
    always_ff @(posedge clock_i)
    begin
        conv_o.done <= 1'b0;
        // Released code lines show the inverse of the last code, so stale data cannot pass
        conv_o.code <= ~last;
        if (reset_i)
        begin
            busy <= 1'b0;
            wait_cnt <= 4'h0;
            last <= 8'h00;
        end
        else if (req_i && !busy)
        begin
            busy <= 1'b1;
            wait_cnt <= latency_i;
        end
        else if (busy && wait_cnt != 4'h0)
        begin
            wait_cnt <= wait_cnt - 4'h1;
        end
        else if (busy)
        begin
            busy <= 1'b0;
            conv_o.done <= 1'b1;
            conv_o.code <= code_i;
            last <= code_i;
        end
    end
endmodule // hkadc_conv_model
`default_nettype wire

// ---- verif/tb_hkadc_ctrl.sv ----
// Self-checking bench for the housekeeping converter control block
`timescale 1ns/1ps
`default_nettype none
module tb_hkadc_ctrl;
    import hkadc_pkg::*;
    logic clock_i;
    logic reset_i;
    hkadc_sfr_t sfr;
    logic [7:0] rdata;
    hkadc_mode_t mode;
    logic tick;
    hkadc_conv_t conv;
    logic req;
    hkadc_chan_t chan;
    logic temp_irq;
    logic ext_irq;
    logic psm_irq;
    logic [3:0] lat;
    logic [7:0] code;
    int miscompares;
    int n_tests;

    hkadc_ctrl u_hkadc_ctrl (.clock_i(clock_i), .reset_i(reset_i), .sfr_i(sfr),
        .sfr_rdata_o(rdata), .mode_i(mode), .interval_tick_i(tick), .conv_i(conv),
        .conv_req_o(req), .conv_chan_o(chan), .temp_irq_o(temp_irq), .ext_irq_o(ext_irq),
        .psm_irq_o(psm_irq));
    hkadc_conv_model u_hkadc_conv_model (.clock_i(clock_i), .reset_i(reset_i), .req_i(req),
        .latency_i(lat), .code_i(code), .conv_o(conv));

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %0t bit %b expected %b", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        sfr <= '{a, 1'b1, d};
        @(posedge clock_i);
        sfr.wr <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock_i);
        sfr.addr <= a;
        @(posedge clock_i);
        #1;
        chk8(rdata, exp);
    endtask
    task automatic tk();
        @(posedge clock_i);
        tick <= 1'b1;
        @(posedge clock_i);
        tick <= 1'b0;
    endtask
    task automatic md(input hkadc_mode_t m);
        @(posedge clock_i);
        mode <= m;
    endtask
    task automatic nq();
        logic seen;
        seen = 1'b0;
        repeat (20)
        begin
            @(posedge clock_i);
            #1;
            if (req !== 1'b0)
                seen = 1'b1;
        end
        chk1(seen, 1'b0);
    endtask
    // Alternates a prompt and a slow converter answer
    task automatic cv(input hkadc_chan_t c, input logic [7:0] v, input logic et, input logic ee);
        int i;
        code <= v;
        lat <= (lat == 4'h0) ? 4'h5 : 4'h0;
        i = 0;
        do
        begin
            @(posedge clock_i);
            #1;
            i++;
        end
        while (req !== 1'b1 && i < 40);
        chk1(req, 1'b1);
        chk8({6'h00, chan}, {6'h00, c});
        i = 0;
        do
        begin
            @(posedge clock_i);
            #1;
            i++;
        end
        while (conv.done !== 1'b1 && i < 40);
        @(posedge clock_i);
        #1;
        chk1(temp_irq, et);
        chk1(ext_irq, ee);
    endtask

    task automatic t_regs();
        rdc(ADDR_STROBE_PER, 8'h00);
        tk();
        nq();
        wr(ADDR_DELTA_CFG, 8'hFF);
        rdc(ADDR_DELTA_CFG, 8'h3F);
        wr(ADDR_IRQ_ENABLE, 8'hFF);
        rdc(ADDR_IRQ_ENABLE, 8'h03);
        wr(ADDR_TEMP_RESULT, 8'hAA);
        rdc(ADDR_TEMP_RESULT, 8'h00);
        rdc(8'h80, 8'h00);
        rdc(ADDR_BAT_THRESH, 8'h00);
        wr(ADDR_DELTA_CFG, 8'h00);
        wr(ADDR_IRQ_ENABLE, 8'h00);
    endtask
    task automatic t_temp();
        wr(ADDR_CONV_START, 8'h02);
        cv(CH_TEMP, 8'h40, 1'b1, 1'b0);
        rdc(ADDR_CONV_START, 8'h00);
        rdc(ADDR_TEMP_RESULT, 8'h40);
        rdc(ADDR_IRQ_FLAGS, 8'h00);
        wr(ADDR_DELTA_CFG, 8'h10);
        wr(ADDR_STROBE_PER, 8'h10);
        tk();
        cv(CH_TEMP, 8'h42, 1'b0, 1'b0);
        rdc(ADDR_TEMP_RESULT, 8'h40);
        tk();
        cv(CH_TEMP, 8'h3D, 1'b1, 1'b0);
        tk();
        cv(CH_TEMP, 8'h3B, 1'b0, 1'b0);
        wr(ADDR_DELTA_CFG, 8'h00);
        tk();
        cv(CH_TEMP, 8'hFF, 1'b0, 1'b0);
        wr(ADDR_DELTA_CFG, 8'h38);
        tk();
        cv(CH_TEMP, 8'h3D, 1'b1, 1'b0);
        md(MODE_BATT);
        tk();
        nq();
        wr(ADDR_CONV_START, 8'h02);
        cv(CH_TEMP, 8'h3D, 1'b1, 1'b0);
        md(MODE_SLEEP);
        tk();
        cv(CH_TEMP, 8'h3D, 1'b1, 1'b0);
        wr(ADDR_CONV_START, 8'h02);
        nq();
        md(MODE_FULL);
        cv(CH_TEMP, 8'h3D, 1'b1, 1'b0);
        wr(ADDR_STROBE_PER, 8'h00);
        wr(ADDR_DELTA_CFG, 8'h00);
    endtask
    task automatic t_bat();
        wr(ADDR_CONV_START, 8'h01);
        cv(CH_BAT, 8'h80, 1'b0, 1'b0);
        rdc(ADDR_IRQ_FLAGS, 8'h01);
        rdc(ADDR_BAT_RESULT, 8'h80);
        chk1(psm_irq, 1'b0);
        wr(ADDR_IRQ_ENABLE, 8'h01);
        rdc(ADDR_IRQ_FLAGS, 8'h01);
        chk1(psm_irq, 1'b1);
        wr(ADDR_IRQ_FLAGS, 8'h00);
        rdc(ADDR_IRQ_FLAGS, 8'h00);
        chk1(psm_irq, 1'b0);
        wr(ADDR_BAT_THRESH, 8'h10);
        wr(ADDR_STROBE_PER, 8'h01);
        tk();
        cv(CH_BAT, 8'h10, 1'b0, 1'b0);
        rdc(ADDR_IRQ_FLAGS, 8'h00);
        rdc(ADDR_BAT_RESULT, 8'h80);
        tk();
        cv(CH_BAT, 8'h0F, 1'b0, 1'b0);
        rdc(ADDR_IRQ_FLAGS, 8'h01);
        rdc(ADDR_BAT_RESULT, 8'h0F);
        chk1(psm_irq, 1'b1);
        wr(ADDR_IRQ_FLAGS, 8'h00);
        md(MODE_BATT);
        tk();
        nq();
        wr(ADDR_CONV_START, 8'h01);
        cv(CH_BAT, 8'h20, 1'b0, 1'b0);
        md(MODE_SLEEP);
        tk();
        nq();
        wr(ADDR_CONV_START, 8'h01);
        nq();
        md(MODE_FULL);
        cv(CH_BAT, 8'h21, 1'b0, 1'b0);
        wr(ADDR_STROBE_PER, 8'h00);
        wr(ADDR_IRQ_FLAGS, 8'h00);
        wr(ADDR_IRQ_ENABLE, 8'h00);
    endtask
    task automatic t_ext();
        wr(ADDR_CONV_START, 8'h04);
        cv(CH_EXT, 8'h50, 1'b0, 1'b1);
        rdc(ADDR_EXT_RESULT, 8'h50);
        rdc(ADDR_IRQ_FLAGS, 8'h00);
        wr(ADDR_DELTA_CFG, 8'h03);
        wr(ADDR_IRQ_ENABLE, 8'h02);
        wr(ADDR_STROBE_PER, 8'h04);
        md(MODE_SLEEP);
        tk();
        cv(CH_EXT, 8'h53, 1'b0, 1'b0);
        rdc(ADDR_EXT_RESULT, 8'h50);
        chk1(psm_irq, 1'b0);
        tk();
        cv(CH_EXT, 8'h4C, 1'b0, 1'b1);
        rdc(ADDR_IRQ_FLAGS, 8'h02);
        rdc(ADDR_EXT_RESULT, 8'h4C);
        chk1(psm_irq, 1'b1);
        wr(ADDR_IRQ_ENABLE, 8'h00);
        rdc(ADDR_IRQ_FLAGS, 8'h02);
        chk1(psm_irq, 1'b0);
        wr(ADDR_IRQ_FLAGS, 8'h00);
        md(MODE_BATT);
        tk();
        nq();
        wr(ADDR_CONV_START, 8'h04);
        cv(CH_EXT, 8'h4C, 1'b0, 1'b1);
        wr(ADDR_STROBE_PER, 8'h00);
        md(MODE_FULL);
    endtask
    task automatic t_order();
        wr(ADDR_CONV_START, 8'h07);
        cv(CH_BAT, 8'h90, 1'b0, 1'b0);
        cv(CH_TEMP, 8'h91, 1'b1, 1'b0);
        cv(CH_EXT, 8'h92, 1'b0, 1'b1);
        rdc(ADDR_CONV_START, 8'h00);
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end
    initial
    begin
        reset_i = 1'b1;
        sfr = '0;
        mode = MODE_FULL;
        tick = 1'b0;
        lat = 4'h0;
        code = 8'h00;
        miscompares = 0;
        n_tests = 0;
        repeat (3) @(posedge clock_i);
        reset_i <= 1'b0;
        t_regs();
        t_temp();
        t_bat();
        t_ext();
        t_order();
        conclude();
    end
    // The tests need under five hundred cycles; forty times that means a hang
    initial
    begin
        repeat (20000) @(posedge clock_i);
        miscompares++;
        conclude();
    end
endmodule // tb_hkadc_ctrl
`default_nettype wire
